/* File: logic/csm_emcy_builder.sv */
// Eight-byte emergency telegram assembly
`timescale 1ns/1ps
module csm_emcy_builder (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic send_in,
  input wire logic ack_in,
  input wire csm_pkg::csm_fault_t fault_in,
  input wire logic [23:0] hours_in,
  output csm_pkg::csm_emcy_t emcy_out,
  output logic emcy_valid_out
);
  import csm_pkg::*;

  wire csm_emcy_t built;

  assign built.b0 = fault_in.code[7:0];
  assign built.b1 = fault_in.code[15:8];
  assign built.b2 = fault_in.err_reg;
  assign built.b3 = fault_in.number;
  assign built.b4 = fault_in.location;
  assign built.b5 = hours_in[7:0];
  assign built.b6 = hours_in[15:8];
  assign built.b7 = hours_in[23:16];

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      emcy_out <= '0;
      emcy_valid_out <= 1'b0;
    end else begin
      emcy_valid_out <= send_in | ack_in;
      if (ack_in) begin
        emcy_out <= '0;
      end else if (send_in) begin
        emcy_out <= built;
      end
    end
  end
endmodule

/* File: logic/csm_ff_scale.sv */
// Percent scaler for one feed-forward channel
`timescale 1ns/1ps
module csm_ff_scale #(
  parameter int W = 32
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic signed [W-1:0] value_in,
  input wire logic [6:0] percent_in,
  output logic signed [W-1:0] scaled_out
);
  import csm_pkg::*;

  wire logic [6:0] pct_clip;
  wire logic signed [W+8:0] product;
  wire logic signed [W+8:0] quotient;

  // Factors above full scale are clipped to 100 percent
  assign pct_clip = (percent_in > CSM_SCALE_FULL) ? CSM_SCALE_FULL : percent_in;
  assign product = value_in * $signed({2'b00, pct_clip});
  assign quotient = product / $signed({{(W+2){1'b0}}, CSM_SCALE_FULL});

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      scaled_out <= '0;
    end else begin
      scaled_out <= quotient[W-1:0];
    end
  end
endmodule

/* File: logic/csm_pkg.sv */
// Package: object indices, field positions, reset values and types for the cyclic setpoint handler
package csm_pkg;

  localparam logic [15:0] CSM_IDX_TORQUE_SP = 16'h6071;
  localparam logic [15:0] CSM_IDX_POSITION_SP = 16'h607a;
  localparam logic [15:0] CSM_IDX_SPEED_FF_OFS = 16'h60b1;
  localparam logic [15:0] CSM_IDX_TORQUE_FF_OFS = 16'h60b2;
  localparam logic [15:0] CSM_IDX_SPEED_SP = 16'h60ff;

  localparam logic [7:0] CSM_MODE_CSP = 8'h08;
  localparam logic [7:0] CSM_MODE_CSV = 8'h09;
  localparam logic [7:0] CSM_MODE_CST = 8'h0a;

  localparam int CSM_SW_SETPOINT_BIT = 12;
  localparam int CSM_CW_FAULT_RESET_BIT = 7;

  localparam logic [15:0] CSM_EMCY_BUS_CODE = 16'hff00;
  localparam logic [15:0] CSM_RATED_PERMILLE = 16'h03e8;
  localparam logic [6:0] CSM_SCALE_FULL = 7'h64;

  localparam logic [6:0] CSM_SCALE_RESET = 7'h00;
  localparam logic CSM_SRC_INTERNAL = 1'b0;
  localparam logic CSM_FMT_32BIT = 1'b0;
  localparam int CSM_NUM_ERRORS = 16;

  // Hours counter: one full hour of 4 ns cycles
  localparam longint CSM_CLK_HZ = 250_000_000;
  localparam longint CSM_HOUR_S = 3600;
  localparam longint CSM_HOUR_CYCLES = CSM_CLK_HZ * CSM_HOUR_S;

  typedef enum logic [1:0] {
    CSM_IP_LINEAR,
    CSM_IP_CUBIC,
    CSM_IP_SPLINE,
    CSM_IP_SPLINE_EXT_FF
  } csm_interp_t;

  typedef enum logic [1:0] {
    CSM_REACT_NONE,
    CSM_REACT_QUICK_STOP,
    CSM_REACT_DISABLE,
    CSM_REACT_COAST
  } csm_react_t;

  typedef struct packed {
    logic [6:0] speed_feedforward_scale;
    logic [6:0] torque_feedforward_scale;
    logic speed_source_select;
    logic torque_source_select;
    logic setpoint_format_select;
    csm_interp_t interpolation_type_select;
  } csm_cfg_t;

  typedef struct packed {
    logic [15:0] code;
    logic [7:0] err_reg;
    logic [7:0] number;
    logic [7:0] location;
  } csm_fault_t;

  typedef struct packed {
    logic [7:0] b7;
    logic [7:0] b6;
    logic [7:0] b5;
    logic [7:0] b4;
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } csm_emcy_t;

endpackage

/* File: logic/csm_top.sv */
// Cyclic position, velocity and torque setpoint handling with feed-forward and emergency reporting
`timescale 1ns/1ps
module csm_top (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic cycle_in,
  input wire logic [7:0] mode_in,
  input wire logic [15:0] control_word_in,
  input wire logic wr_in,
  input wire logic [15:0] wr_index_in,
  input wire logic [31:0] wr_data_in,
  input wire csm_pkg::csm_cfg_t cfg_in,
  input wire logic [1:0] setpoint_hold_in,
  input wire logic signed [31:0] int_speed_ff_in,
  input wire logic signed [15:0] int_torque_ff_in,
  input wire logic [csm_pkg::CSM_NUM_ERRORS-1:0] fault_cause_in,
  input wire csm_pkg::csm_fault_t fault_info_in,
  input wire logic [2*csm_pkg::CSM_NUM_ERRORS-1:0] react_cfg_in,
  input wire logic bus_fault_in,
  output logic [31:0] position_ref_out,
  output logic signed [31:0] speed_ref_out,
  output logic signed [15:0] torque_ref_out,
  output logic signed [31:0] speed_ff_out,
  output logic signed [15:0] torque_ff_out,
  output logic [2:0] loop_enable_out,
  output logic setpoint_used_out,
  output csm_pkg::csm_interp_t interp_out,
  output logic cfg_refused_out,
  output logic fault_active_out,
  output csm_pkg::csm_react_t reaction_out,
  output csm_pkg::csm_emcy_t emcy_out,
  output logic emcy_valid_out,
  output logic [23:0] hours_out
);
  import csm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Process data objects written by the controller

  logic [31:0] position_setpoint_ff;
  logic [31:0] speed_setpoint_ff;
  logic [15:0] torque_setpoint_ff;
  logic [31:0] speed_feedforward_offset_ff;
  logic [15:0] torque_feedforward_offset_ff;
  csm_interp_t interp_ff;
  logic cfg_refused_ff;

  wire logic wr_pos = wr_in && (wr_index_in == CSM_IDX_POSITION_SP);
  wire logic wr_spd = wr_in && (wr_index_in == CSM_IDX_SPEED_SP);
  wire logic wr_trq = wr_in && (wr_index_in == CSM_IDX_TORQUE_SP);
  wire logic wr_sofs = wr_in && (wr_index_in == CSM_IDX_SPEED_FF_OFS);
  wire logic wr_tofs = wr_in && (wr_index_in == CSM_IDX_TORQUE_FF_OFS);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      position_setpoint_ff <= '0;
      speed_setpoint_ff <= '0;
      torque_setpoint_ff <= '0;
      speed_feedforward_offset_ff <= '0;
      torque_feedforward_offset_ff <= '0;
    end else begin
      if (wr_pos) begin
        position_setpoint_ff <= wr_data_in;
      end
      if (wr_spd) begin
        speed_setpoint_ff <= wr_data_in;
      end
      if (wr_trq) begin
        torque_setpoint_ff <= wr_data_in[15:0];
      end
      if (wr_sofs) begin
        speed_feedforward_offset_ff <= wr_data_in;
      end
      if (wr_tofs) begin
        torque_feedforward_offset_ff <= wr_data_in[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode and status bit 12

  wire logic is_csp = (mode_in == CSM_MODE_CSP);
  wire logic is_csv = (mode_in == CSM_MODE_CSV);
  wire logic is_cst = (mode_in == CSM_MODE_CST);
  wire logic setpoint_taken = !fault_active_out && !(|setpoint_hold_in);
  wire logic nxt_used = (is_csp || is_csv || is_cst) && setpoint_taken;

  // Interpolation selection: the spline-with-external-FF code is refused and the last legal one kept
  wire logic interp_bad = (cfg_in.interpolation_type_select == CSM_IP_SPLINE_EXT_FF);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      interp_ff <= CSM_IP_LINEAR;
      cfg_refused_ff <= 1'b0;
    end else begin
      cfg_refused_ff <= interp_bad;
      if (!interp_bad) begin
        interp_ff <= cfg_in.interpolation_type_select;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Feed-forward source selection and scaling

  wire logic ext_ok = is_csp || is_csv;
  wire logic speed_ext = ext_ok && (cfg_in.speed_source_select != CSM_SRC_INTERNAL);
  wire logic torque_ext = ext_ok && (cfg_in.torque_source_select != CSM_SRC_INTERNAL);
  wire logic signed [31:0] speed_ff_raw =
    speed_ext ? $signed(speed_feedforward_offset_ff) : int_speed_ff_in;
  wire logic signed [15:0] torque_ff_raw =
    torque_ext ? $signed(torque_feedforward_offset_ff) : int_torque_ff_in;
  wire logic signed [31:0] speed_ff_scaled;
  wire logic signed [15:0] torque_ff_scaled;

  csm_ff_scale #(.W(32)) u_speed_scale (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .value_in(speed_ff_raw),
    .percent_in(cfg_in.speed_feedforward_scale),
    .scaled_out(speed_ff_scaled)
  );

  csm_ff_scale #(.W(16)) u_torque_scale (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .value_in(torque_ff_raw),
    .percent_in(cfg_in.torque_feedforward_scale),
    .scaled_out(torque_ff_scaled)
  );

  // Torque sum saturates rather than wrapping; per-mille of rated torque throughout
  wire logic signed [16:0] torque_sum =
    $signed({torque_setpoint_ff[15], torque_setpoint_ff}) +
    $signed({torque_feedforward_offset_ff[15], torque_feedforward_offset_ff});
  wire logic signed [15:0] torque_sat =
    (torque_sum > 17'sh07fff) ? 16'sh7fff :
    (torque_sum < -17'sh08000) ? -16'sh8000 : torque_sum[15:0];

  //////////////////////////////////////////////////////////////////////////////
  // Cycle-synchronous reference outputs; feed-forward outputs and the used flag are registered every clock

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      position_ref_out <= '0;
      speed_ref_out <= '0;
      torque_ref_out <= '0;
      speed_ff_out <= '0;
      torque_ff_out <= '0;
      loop_enable_out <= 3'b000;
      setpoint_used_out <= 1'b0;
    end else begin
      setpoint_used_out <= nxt_used;
      speed_ff_out <= speed_ff_scaled;
      torque_ff_out <= torque_ff_scaled;
      if (cycle_in && nxt_used) begin
        if (is_csp) begin
          position_ref_out <= position_setpoint_ff;
          loop_enable_out <= 3'b111;
        end else if (is_csv) begin
          speed_ref_out <= $signed(speed_setpoint_ff);
          loop_enable_out <= 3'b011;
        end else begin
          torque_ref_out <= torque_sat;
          loop_enable_out <= 3'b001;
        end
      end else if (!(is_csp || is_csv || is_cst)) begin
        loop_enable_out <= 3'b000;
      end
    end
  end

  assign interp_out = interp_ff;
  assign cfg_refused_out = cfg_refused_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Operating hours counter

  logic [39:0] hour_tick_ff;
  logic [23:0] hours_ff;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      hour_tick_ff <= '0;
      hours_ff <= '0;
    end else if (hour_tick_ff == 40'(CSM_HOUR_CYCLES - 1)) begin
      hour_tick_ff <= '0;
      hours_ff <= hours_ff + 24'h00_0001;
    end else begin
      hour_tick_ff <= hour_tick_ff + 40'h00_0000_0001;
    end
  end

  assign hours_out = hours_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Fault handling and acknowledge

  logic fault_ff;
  logic cw7_ff;
  csm_react_t react_ff;

  wire logic any_cause = (|fault_cause_in) || bus_fault_in;
  wire logic ack_edge = control_word_in[CSM_CW_FAULT_RESET_BIT] && !cw7_ff;
  wire logic raise = any_cause && !fault_ff && !ack_edge;
  wire logic clear = fault_ff && ack_edge;
  wire csm_fault_t nxt_fault;
  wire csm_react_t sel_react;

  // Bus faults take the fixed profile code; others bring their own
  assign nxt_fault.code = bus_fault_in ? CSM_EMCY_BUS_CODE : fault_info_in.code;
  assign nxt_fault.err_reg = fault_info_in.err_reg;
  assign nxt_fault.number = fault_info_in.number;
  assign nxt_fault.location = fault_info_in.location;

  // Lowest-numbered active cause picks the reaction
  function automatic csm_react_t pick_react(input logic [CSM_NUM_ERRORS-1:0] c,
                                            input logic [2*CSM_NUM_ERRORS-1:0] r);
    csm_react_t res;
    res = CSM_REACT_NONE;
    for (int i = CSM_NUM_ERRORS - 1; i >= 0; i--) begin
      if (c[i]) begin
        res = csm_react_t'(r[2*i +: 2]);
      end
    end
    return res;
  endfunction

  assign sel_react = bus_fault_in ? csm_react_t'(react_cfg_in[1:0]) :
    pick_react(fault_cause_in, react_cfg_in);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fault_ff <= 1'b0;
      cw7_ff <= 1'b0;
      react_ff <= CSM_REACT_NONE;
    end else begin
      cw7_ff <= control_word_in[CSM_CW_FAULT_RESET_BIT];
      if (clear) begin
        fault_ff <= 1'b0;
        react_ff <= CSM_REACT_NONE;
      end else if (raise) begin
        fault_ff <= 1'b1;
        react_ff <= sel_react;
      end
    end
  end

  assign fault_active_out = fault_ff;
  assign reaction_out = react_ff;

  csm_emcy_builder u_emcy (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .send_in(raise),
    .ack_in(clear),
    .fault_in(nxt_fault),
    .hours_in(hours_ff),
    .emcy_out(emcy_out),
    .emcy_valid_out(emcy_valid_out)
  );

endmodule

/* File: verif/csm_master_model.sv */
// Fieldbus master model: object writes and bus-cycle pulses
`timescale 1ns/1ps
module csm_master_model (
  input wire logic clk_in,
  output logic cycle_out,
  output logic wr_out,
  output logic [15:0] idx_out,
  output logic [31:0] data_out
);
  initial begin
    cycle_out = 1'b0;
    wr_out = 1'b0;
    idx_out = 16'h0000;
    data_out = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse so a stale value is never mistaken for data
  task automatic put(input logic [15:0] idx, input logic [31:0] data);
    @(posedge clk_in);
    #1;
    wr_out = 1'b1;
    idx_out = idx;
    data_out = data;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    idx_out = ~idx;
    data_out = ~data;
  endtask
  // One setpoint taken per bus cycle
  task automatic sync();
    @(posedge clk_in);
    #1;
    cycle_out = 1'b1;
    @(posedge clk_in);
    #1;
    cycle_out = 1'b0;
  endtask
endmodule

/* File: verif/csm_top_asserts.sv */
// Port-level checker for the cyclic setpoint handler
`timescale 1ns/1ps
module csm_top_asserts (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic cycle_in,
  input wire logic [7:0] mode_in,
  input wire logic [15:0] control_word_in,
  input wire csm_pkg::csm_cfg_t cfg_in,
  input wire logic [1:0] setpoint_hold_in,
  input wire logic [csm_pkg::CSM_NUM_ERRORS-1:0] fault_cause_in,
  input wire csm_pkg::csm_fault_t fault_info_in,
  input wire logic bus_fault_in,
  input wire logic [2:0] loop_enable_out,
  input wire logic setpoint_used_out,
  input wire csm_pkg::csm_interp_t interp_out,
  input wire logic cfg_refused_out,
  input wire logic fault_active_out,
  input wire csm_pkg::csm_emcy_t emcy_out,
  input wire logic emcy_valid_out,
  input wire logic [23:0] hours_out
);
  import csm_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////////////////////////////////////
  // Past-reset guards: the flops hold zero on the first edge after release
  // Loop enables follow the bus cycle on which the setpoint was taken, not the bare mode
  a_loop_pos_mode: assert property ($past(cycle_in) && setpoint_used_out &&
    $past(mode_in) == CSM_MODE_CSP |-> loop_enable_out == 3'h7)
    else $error("loop enables wrong in position mode");
  a_loop_vel_mode: assert property ($past(cycle_in) && setpoint_used_out &&
    $past(mode_in) == CSM_MODE_CSV |-> loop_enable_out == 3'h3)
    else $error("loop enables wrong in velocity mode");
  a_loop_trq_mode: assert property ($past(cycle_in) && setpoint_used_out &&
    $past(mode_in) == CSM_MODE_CST |-> loop_enable_out == 3'h1)
    else $error("loop enables wrong in torque mode");
  a_hold_not_used: assert property ($past(resetn_in) && $past(setpoint_hold_in) != 2'h0 |->
    !setpoint_used_out)
    else $error("setpoint flagged used while held");
  a_used_needs_mode: assert property (setpoint_used_out |->
    $past(mode_in) inside {[8'h08:8'h0a]})
    else $error("setpoint flagged used outside cyclic modes");
  a_raise_telegram: assert property ($rose(fault_active_out) && !$past(bus_fault_in)
    |-> emcy_valid_out && emcy_out[39:0] ==
    {$past(fault_info_in.location), $past(fault_info_in.number),
    $past(fault_info_in.err_reg), $past(fault_info_in.code)})
    else $error("fault telegram bytes wrong");
  a_bus_code: assert property ($rose(fault_active_out) && $past(bus_fault_in) &&
    $past(fault_cause_in) == '0 |-> emcy_valid_out && {emcy_out.b1, emcy_out.b0} == CSM_EMCY_BUS_CODE)
    else $error("bus fault code wrong");
  a_hours_bytes: assert property (emcy_valid_out && fault_active_out |->
    {emcy_out.b7, emcy_out.b6, emcy_out.b5} == $past(hours_out))
    else $error("hours bytes wrong");
  a_ack_clears: assert property ($rose(control_word_in[7]) && fault_active_out |=>
    !fault_active_out && emcy_valid_out && emcy_out == 64'h0000_0000_0000_0000)
    else $error("acknowledge did not clear with zero telegram");
  a_refuse_spline: assert property ($past(resetn_in) &&
    $past(cfg_in.interpolation_type_select) == CSM_IP_SPLINE_EXT_FF |-> cfg_refused_out && $stable(interp_out))
    else $error("reserved interpolation not refused");
endmodule
bind csm_top csm_top_asserts u_chk (.*);

/* File: verif/csm_top_bench.sv */
// Self-checking bench for the cyclic setpoint handler
`timescale 1ns/1ps
module csm_top_bench;
  import csm_pkg::*;
  logic clk_in, resetn_in, cycle, wr, bus_fault, used, refused, fault, valid;
  logic [7:0] mode;
  logic [15:0] cw, idx, cause, int_tff, trq_ref, tff;
  logic [31:0] data, react, int_sff, pos_ref, spd_ref, sff;
  logic [1:0] hold;
  logic [2:0] loop_en;
  logic [23:0] hours;
  csm_cfg_t cfg;
  csm_fault_t finfo;
  csm_interp_t interp;
  csm_react_t react_out;
  csm_emcy_t emcy;
  int fails, num_checks;
  csm_master_model u_master (.clk_in(clk_in), .cycle_out(cycle), .wr_out(wr), .idx_out(idx), .data_out(data));
  csm_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .cycle_in(cycle), .mode_in(mode), .control_word_in(cw),
    .wr_in(wr), .wr_index_in(idx), .wr_data_in(data), .cfg_in(cfg), .setpoint_hold_in(hold),
    .int_speed_ff_in(int_sff), .int_torque_ff_in(int_tff), .fault_cause_in(cause), .fault_info_in(finfo),
    .react_cfg_in(react), .bus_fault_in(bus_fault), .position_ref_out(pos_ref), .speed_ref_out(spd_ref),
    .torque_ref_out(trq_ref), .speed_ff_out(sff), .torque_ff_out(tff), .loop_enable_out(loop_en),
    .setpoint_used_out(used), .interp_out(interp), .cfg_refused_out(refused), .fault_active_out(fault),
    .reaction_out(react_out), .emcy_out(emcy), .emcy_valid_out(valid), .hours_out(hours));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // The telegram strobe stands one cycle, so it is looked at after every edge
  task automatic wait_emcy();
    int i;
    for (i = 0; i < 20; i++) begin
      step(1);
      if (valid === 1'b1) break;
    end
    if (i == 20) begin
      fails++;
      $display("Error t=%0t no telegram", $time);
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    logic [31:0] v;
    u_master.put(CSM_IDX_TORQUE_FF_OFS, 32'h0000_0000);
    for (int m = 0; m < 3; m++) begin
      mode = CSM_MODE_CSP + 8'(m);
      v = 32'h1234_5678 + 32'(m);
      u_master.put(m == 0 ? CSM_IDX_POSITION_SP : m == 1 ? CSM_IDX_SPEED_SP : CSM_IDX_TORQUE_SP, v);
      u_master.sync();
      step(1);
      if (m == 0) chk(pos_ref, v);
      if (m == 1) chk(spd_ref, v);
      if (m == 2) chk(trq_ref, v[15:0]);
      chk(loop_en, {m == 0, m < 2, 1'b1});
      chk(used, 1'b1);
    end
    mode = CSM_MODE_CSP;
    u_master.put(16'h6040, 32'h0bad_0bad);
    u_master.sync();
    step(1);
    chk(pos_ref, 32'h1234_5678);
    hold = 2'h1;
    u_master.put(CSM_IDX_POSITION_SP, 32'h5555_aaaa);
    u_master.sync();
    step(1);
    chk(pos_ref, 32'h1234_5678);
    chk(used, 1'b0);
    hold = 2'h0;
    mode = 8'h07;
    step(2);
    chk(loop_en, 3'h0);
    chk(used, 1'b0);
    $display("t_modes done");
  endtask
  task automatic t_torque();
    mode = CSM_MODE_CST;
    u_master.put(CSM_IDX_TORQUE_SP, 32'h0000_0064);
    u_master.put(CSM_IDX_TORQUE_FF_OFS, 32'h0000_03e8);
    u_master.sync();
    step(1);
    chk(trq_ref, 16'h044c);
    u_master.put(CSM_IDX_TORQUE_SP, 32'h0000_7fff);
    u_master.sync();
    step(1);
    chk(trq_ref, 16'h7fff);
    $display("t_torque done");
  endtask
  task automatic t_ff();
    cfg.speed_source_select = 1'b1;
    cfg.torque_source_select = 1'b1;
    cfg.speed_feedforward_scale = 7'h32;
    cfg.torque_feedforward_scale = 7'h32;
    u_master.put(CSM_IDX_SPEED_FF_OFS, 32'h0000_03e8);
    u_master.put(CSM_IDX_TORQUE_FF_OFS, 32'h0000_00c8);
    for (int m = 0; m < 2; m++) begin
      mode = CSM_MODE_CSP + 8'(m);
      step(4);
      chk(sff, 32'h0000_01f4);
      chk(tff, 16'h0064);
    end
    cfg.speed_source_select = CSM_SRC_INTERNAL;
    cfg.torque_source_select = CSM_SRC_INTERNAL;
    cfg.speed_feedforward_scale = CSM_SCALE_FULL;
    cfg.torque_feedforward_scale = CSM_SCALE_FULL;
    int_sff = 32'h0000_04d2;
    int_tff = 16'hfffb;
    step(4);
    chk(sff, 32'h0000_04d2);
    chk(tff, 16'hfffb);
    cfg.speed_source_select = 1'b1;
    cfg.torque_source_select = 1'b1;
    mode = CSM_MODE_CST;
    step(4);
    chk(sff, 32'h0000_04d2);
    chk(tff, 16'hfffb);
    cfg.speed_source_select = CSM_SRC_INTERNAL;
    cfg.torque_source_select = CSM_SRC_INTERNAL;
    $display("t_ff done");
  endtask
  task automatic t_interp();
    for (int i = 0; i < 4; i++) begin
      cfg.interpolation_type_select = csm_interp_t'(i);
      step(3);
      chk(interp, i == 3 ? CSM_IP_SPLINE : csm_interp_t'(i));
      chk(refused, i == 3);
    end
    cfg.interpolation_type_select = CSM_IP_LINEAR;
    $display("t_interp done");
  endtask
  task automatic t_fault();
    finfo = '{code: 16'h2310, err_reg: 8'h02, number: 8'h41, location: 8'h07};
    react = 32'h0000_0c12;
    cause = 16'h0024;
    wait_emcy();
    chk(emcy, 64'h0000_0007_4102_2310);
    step(1);
    chk(react_out, CSM_REACT_QUICK_STOP);
    cw = 16'h0080;
    step(1);
    chk({fault, valid, emcy}, {2'h1, 64'h0});
    step(1);
    chk({fault, valid}, 2'h3);
    cause = 16'h0000;
    cw = 16'h0000;
    step(2);
    cw = 16'h0080;
    step(1);
    chk({fault, valid, emcy}, {2'h1, 64'h0});
    cw = 16'h0000;
    bus_fault = 1'b1;
    wait_emcy();
    chk({emcy.b1, emcy.b0}, CSM_EMCY_BUS_CODE);
    step(1);
    chk(react_out, CSM_REACT_DISABLE);
    bus_fault = 1'b0;
    cw = 16'h0080;
    step(1);
    chk(fault, 1'b0);
    cw = 16'h0000;
    $display("t_fault done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    mode = CSM_MODE_CSP;
    cw = 16'h0000;
    cfg = '0;
    hold = 2'h0;
    int_sff = 32'h0000_0000;
    int_tff = 16'h0000;
    cause = 16'h0000;
    finfo = '0;
    react = 32'h0000_0000;
    bus_fault = 1'b0;
    step(3);
    resetn_in = 1'b1;
    chk({pos_ref, loop_en, fault, interp, hours}, 0);
    t_modes();
    t_torque();
    t_ff();
    t_interp();
    t_fault();
    end_sim();
  end
endmodule
